// ---- wsp_pkg.sv ----
package wsp_pkg;
  // Parameter selectors
  typedef enum logic [4:0] {
    WSP_P_FREQ = 5'h00,
    WSP_P_RATE = 5'h01,
    WSP_P_AMPL = 5'h02,
    WSP_P_OFFS = 5'h03,
    WSP_P_SHAPE = 5'h04,
    WSP_P_MODUL = 5'h05,
    WSP_P_DEPTH = 5'h06,
    WSP_P_MODTONE = 5'h07,
    WSP_P_MODWAVE = 5'h08,
    WSP_P_DEV = 5'h09,
    WSP_P_SWEEP = 5'h0A,
    WSP_P_CHIRPDUR = 5'h0B,
    WSP_P_CHIRPBEG = 5'h0C,
    WSP_P_CHIRPEND = 5'h0D,
    WSP_P_SYMM = 5'h0E,
    WSP_P_OUT = 5'h0F,
    WSP_P_TMODE = 5'h10,
    WSP_P_TSRC = 5'h11,
    WSP_P_BUSTRG = 5'h12
  } wsp_param_t;

  // Argument kinds
  typedef enum logic [1:0] {
    WSP_A_VALUE = 2'h0,
    WSP_A_MIN = 2'h1,
    WSP_A_MAX = 2'h2
  } wsp_arg_t;

  // Shape and keyword codes
  localparam logic [1:0] WSP_SH_SIN = 2'h0;
  localparam logic [1:0] WSP_SH_SQU = 2'h1;
  localparam logic [1:0] WSP_SH_TRI = 2'h2;
  localparam logic [1:0] WSP_SH_USR = 2'h3;
  localparam logic [2:0] WSP_MK_OFF = 3'h0;
  localparam logic [2:0] WSP_MK_AM = 3'h1;
  localparam logic [2:0] WSP_MK_FM = 3'h2;
  localparam logic [2:0] WSP_MK_INT = 3'h3;
  localparam logic [2:0] WSP_MK_EXT = 3'h4;
  localparam logic [1:0] WSP_MT_OFF = 2'h0;
  localparam logic [1:0] WSP_MT_AM = 2'h1;
  localparam logic [1:0] WSP_MT_FM = 2'h2;
  localparam logic [1:0] WSP_SK_ON = 2'h0;
  localparam logic [1:0] WSP_SK_OFF = 2'h1;
  localparam logic [1:0] WSP_SK_LIN = 2'h2;
  localparam logic [1:0] WSP_SK_LOG = 2'h3;
  localparam logic [1:0] WSP_SW_OFF = 2'h0;
  localparam logic [1:0] WSP_SW_LIN = 2'h1;
  localparam logic [1:0] WSP_SW_LOG = 2'h2;
  localparam logic [1:0] WSP_TM_CONT = 2'h0;
  localparam logic [1:0] WSP_TM_TRIG = 2'h1;
  localparam logic [1:0] WSP_TM_GATE = 2'h2;
  localparam logic [1:0] WSP_TM_BURS = 2'h3;
  localparam logic [1:0] WSP_TS_INT = 2'h0;
  localparam logic [1:0] WSP_TS_EXT = 2'h1;
  localparam logic [1:0] WSP_TS_BUS = 2'h2;

  // Error codes (magnitude of the negative code)
  localparam logic [8:0] WSP_ERR_NONE = 9'h000;
  localparam logic [8:0] WSP_ERR_TRG_IGN = 9'h0D3;
  localparam logic [8:0] WSP_ERR_CONFLICT = 9'h0DD;
  localparam logic [8:0] WSP_ERR_RANGE = 9'h0DE;
  localparam logic [8:0] WSP_ERR_ILLEGAL = 9'h0E0;

  // Units: frequency in uHz, time in ns, voltage in mV, 48-bit values (WSP_UHZ_NS is 64-bit)
  localparam logic [47:0] WSP_FREQ_MIN = 48'h0000_0000_000A;
  localparam logic [47:0] WSP_FREQ_MAX_SQ = 48'd31000000000000;
  localparam logic [47:0] WSP_FREQ_MAX_TRI = 48'd500000000000;
  localparam logic [47:0] WSP_STEP_MIN = 48'd20;
  localparam logic [47:0] WSP_STEP_MAX = 48'd50000000000;
  localparam logic [47:0] WSP_STEP_RST = 48'd1000;
  localparam logic [63:0] WSP_UHZ_NS = 64'd1000000000000000;
  localparam logic [47:0] WSP_AMPL_MIN = 48'd10;
  localparam logic [47:0] WSP_AMPL_MAX = 48'd10000;
  localparam logic [47:0] WSP_AMPL_FINE = 48'd1000;
  localparam logic [47:0] WSP_AMPL_RST = 48'd1000;
  localparam logic [47:0] WSP_OFFS_MIN = 48'd10;
  localparam logic [47:0] WSP_OFFS_MAX = 48'd4500;
  localparam logic [47:0] WSP_OFFS_RST = 48'd10;
  localparam logic [47:0] WSP_PEAK_SUM = 48'd5000;
  localparam logic [47:0] WSP_DEPTH_MAX = 48'd100;
  localparam logic [47:0] WSP_DEPTH_RST = 48'd50;
  localparam logic [47:0] WSP_MTONE_MIN = 48'd10000;
  localparam logic [47:0] WSP_MTONE_MAX = 48'd20000000000;
  localparam logic [47:0] WSP_MTONE_RST = 48'd1000000000;
  localparam logic [47:0] WSP_DEV_MAX = 48'd1560000000000;
  localparam logic [47:0] WSP_DEV_RST = 48'd100000000;
  localparam logic [47:0] WSP_CDUR_MIN = 48'd10000000;
  localparam logic [47:0] WSP_CDUR_MAX = 48'd500000000000;
  localparam logic [47:0] WSP_CDUR_RST = 48'd1000000000;
  localparam logic [47:0] WSP_SYMM_MIN = 48'd20;
  localparam logic [47:0] WSP_SYMM_MAX = 48'd80;
  localparam logic [47:0] WSP_SYMM_RST = 48'd50;
  localparam logic [47:0] WSP_FREQ_RST = 48'd1000000000;
  localparam logic [47:0] WSP_CBEG_RST = 48'd100000000;
  localparam logic [47:0] WSP_CEND_RST = 48'd10000000000;
  localparam int WSP_DIG_SYNTH = 10;
  localparam int WSP_DIG_COARSE = 4;
endpackage

// ---- wsp_rounder.sv ----
`timescale 1ns/10ps
// Rounds a value to a number of significant decimal digits
module wsp_rounder #(
  parameter int W = 48,
  parameter int MAXDIG = 16
) (
  input wire logic [W-1:0] value,
  input wire logic [4:0] digits,
  output logic [W-1:0] rounded
);
  logic [W-1:0] step;
  logic [W-1:0] lim;
  logic [W-1:0] half;
  logic [W:0] sum;

  always_comb
  begin
    step = W'(1);
    lim = W'(1);
    for (int i = 0; i < MAXDIG; i++)
    begin
      if (i < int'(digits))
        lim = W'(lim * W'(10));
    end
    // Grow the step until value fits in the digit budget
    for (int i = 0; i < MAXDIG; i++)
    begin
      if (value >= W'(lim * step))
        step = W'(step * W'(10));
    end
    half = step >> 1;
    sum = {1'b0, value} + {1'b0, half};
    rounded = W'((sum[W-1:0] / step) * step);
  end
endmodule

// ---- wsp_parser.sv ----
`timescale 1ns/10ps
// Summary of operation
// - Sine, square frequency 10 uHz to 31 MHz
// - Triangle frequency 10 uHz to 500 kHz
// - User-table limits from step range and length
// - Frequency rounds 10 digits, user table 4
// - MIN/MAX resolved to present settable limits
// - Step 20 ns to 50 s sets frequency
// - Peak plus offset magnitude within five volts
// - Amplitude 10 mV to 10 V, rounded
// - Offset 10 mV to 4.5 V, 10 mV steps
// - Four shapes, query returns active shape
// - Modulation keywords, query type and source
// - AM depth 0 to 100 integer
// - Modulator tone 0.01 Hz to 20 kHz
// - Modulator waveform sine, triangle or square
// - Deviation up to min(carrier, 1.56 MHz)
// - Sweep turn-on refused while user table or FM is set
// - Sweep keywords ON OFF LIN LOG
// - Sweep duration 10 ms to 500 s
// - Sweep endpoints within shape frequency span
// - Symmetry 20 to 80 percent integer
// - Output on/off, query returns 0 or 1
// - Trigger modes and trigger source select
// - Bus trigger only when enabled, else ignored
module wsp_parser #(
  parameter int W = 48,
  parameter logic [9:0] LEN_RST = 10'h3E8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_query,
  input wire wsp_pkg::wsp_param_t cmd_param,
  input wire wsp_pkg::wsp_arg_t cmd_arg,
  input wire logic [W-1:0] cmd_value,
  input wire logic [9:0] table_length,
  output logic rsp_valid,
  output logic [W-1:0] rsp_value,
  output logic [W-1:0] rsp_extra,
  output logic err_valid,
  output logic [8:0] err_code,
  output logic [W-1:0] carrier_freq,
  output logic [W-1:0] step_period,
  output logic [W-1:0] amplitude,
  output logic [W-1:0] offset_mag,
  output logic offset_neg,
  output logic [1:0] shape,
  output logic [1:0] mod_type,
  output logic mod_ext,
  output logic [W-1:0] am_depth,
  output logic [W-1:0] modulator_tone_cmd,
  output logic [1:0] modulator_wave_select,
  output logic [W-1:0] fm_deviation,
  output logic [1:0] sweep_mode,
  output logic [W-1:0] chirp_duration_cmd,
  output logic [W-1:0] chirp_begin_cmd,
  output logic [W-1:0] chirp_end_cmd,
  output logic [W-1:0] pulse_symmetry_cmd,
  output logic out_enable,
  output logic [1:0] trig_mode,
  output logic [1:0] trig_source,
  output logic bus_trigger
);
  typedef enum logic [2:0] {
    WSP_IDLE = 3'b001,
    WSP_ROUND = 3'b010,
    WSP_APPLY = 3'b100
  } wsp_state_t;

  wsp_state_t state;
  wsp_state_t next_state;
  logic held_query;
  wsp_pkg::wsp_param_t held_param;
  wsp_pkg::wsp_arg_t held_arg;
  logic [W-1:0] held_value;
  logic [W-1:0] rnd_out;
  logic [4:0] rnd_digits;
  logic [W-1:0] lo_lim;
  logic [W-1:0] hi_lim;
  logic [W-1:0] cand;
  logic [W-1:0] fmin_now;
  logic [W-1:0] fmax_now;
  logic [W-1:0] usr_fmin;
  logic [W-1:0] usr_fmax;
  logic [W-1:0] len_w;
  logic [W-1:0] ampl_peak;
  logic [W-1:0] ampl_limit;
  logic [W-1:0] offs_limit;
  logic [W-1:0] dev_limit;
  logic [W-1:0] step_freq;
  logic in_range;
  logic conflict;
  logic is_numeric;
  logic bad_keyword;
  logic trg_ok;

  ////////////////////////////////////////////////////////////////////
  // Limits of the present state
  assign len_w = W'(table_length == 10'h000 ? LEN_RST : table_length);
  assign usr_fmax = W'(wsp_pkg::WSP_UHZ_NS / W'(wsp_pkg::WSP_STEP_MIN * len_w));
  assign usr_fmin = W'(wsp_pkg::WSP_UHZ_NS / W'(wsp_pkg::WSP_STEP_MAX * len_w));
  assign fmin_now = (shape == wsp_pkg::WSP_SH_USR) ? usr_fmin : wsp_pkg::WSP_FREQ_MIN;
  assign fmax_now = (shape == wsp_pkg::WSP_SH_USR) ? usr_fmax :
                    (shape == wsp_pkg::WSP_SH_TRI) ? wsp_pkg::WSP_FREQ_MAX_TRI :
                    wsp_pkg::WSP_FREQ_MAX_SQ;
  assign ampl_peak = amplitude >> 1;
  assign ampl_limit = W'((wsp_pkg::WSP_PEAK_SUM - offset_mag) << 1);
  assign offs_limit = (wsp_pkg::WSP_PEAK_SUM - ampl_peak) < wsp_pkg::WSP_OFFS_MAX ?
                      (wsp_pkg::WSP_PEAK_SUM - ampl_peak) : wsp_pkg::WSP_OFFS_MAX;
  assign dev_limit = carrier_freq < wsp_pkg::WSP_DEV_MAX ? carrier_freq :
                     wsp_pkg::WSP_DEV_MAX;
  assign step_freq = W'(wsp_pkg::WSP_UHZ_NS / W'(rnd_out * len_w));

  ////////////////////////////////////////////////////////////////////
  // Per-parameter range selection
  always_comb
  begin
    lo_lim = '0;
    hi_lim = '0;
    is_numeric = 1'b1;
    rnd_digits = 5'(wsp_pkg::WSP_DIG_COARSE);
    unique case (held_param)
      wsp_pkg::WSP_P_FREQ:
      begin
        lo_lim = fmin_now;
        hi_lim = fmax_now;
        rnd_digits = (shape == wsp_pkg::WSP_SH_USR) ? 5'(wsp_pkg::WSP_DIG_COARSE) :
                     5'(wsp_pkg::WSP_DIG_SYNTH);
      end
      wsp_pkg::WSP_P_RATE:
      begin
        lo_lim = wsp_pkg::WSP_STEP_MIN;
        hi_lim = wsp_pkg::WSP_STEP_MAX;
      end
      wsp_pkg::WSP_P_AMPL:
      begin
        lo_lim = wsp_pkg::WSP_AMPL_MIN;
        hi_lim = ampl_limit < wsp_pkg::WSP_AMPL_MAX ? ampl_limit : wsp_pkg::WSP_AMPL_MAX;
        rnd_digits = 5'h03;
      end
      wsp_pkg::WSP_P_OFFS:
      begin
        lo_lim = wsp_pkg::WSP_OFFS_MIN;
        hi_lim = offs_limit;
        rnd_digits = 5'h10;
      end
      wsp_pkg::WSP_P_DEPTH:
      begin
        hi_lim = wsp_pkg::WSP_DEPTH_MAX;
        rnd_digits = 5'h10;
      end
      wsp_pkg::WSP_P_MODTONE:
      begin
        lo_lim = wsp_pkg::WSP_MTONE_MIN;
        hi_lim = wsp_pkg::WSP_MTONE_MAX;
      end
      wsp_pkg::WSP_P_DEV:
      begin
        lo_lim = wsp_pkg::WSP_FREQ_MIN;
        hi_lim = dev_limit;
      end
      wsp_pkg::WSP_P_CHIRPDUR:
      begin
        lo_lim = wsp_pkg::WSP_CDUR_MIN;
        hi_lim = wsp_pkg::WSP_CDUR_MAX;
      end
      wsp_pkg::WSP_P_CHIRPBEG, wsp_pkg::WSP_P_CHIRPEND:
      begin
        lo_lim = fmin_now;
        hi_lim = fmax_now;
      end
      wsp_pkg::WSP_P_SYMM:
      begin
        lo_lim = wsp_pkg::WSP_SYMM_MIN;
        hi_lim = wsp_pkg::WSP_SYMM_MAX;
        rnd_digits = 5'h10;
      end
      default:
      begin
        is_numeric = 1'b0;
      end
    endcase
  end

  // MIN and MAX resolve against the limits as they stand now
  assign cand = (held_arg == wsp_pkg::WSP_A_MIN) ? lo_lim :
                (held_arg == wsp_pkg::WSP_A_MAX) ? hi_lim :
                (held_param == wsp_pkg::WSP_P_OFFS) ? {1'b0, held_value[W-2:0]} :
                held_value;

  wsp_rounder #(
    .W(W),
    .MAXDIG(16)
  ) u_round (
    .value(held_param == wsp_pkg::WSP_P_AMPL && cand >= wsp_pkg::WSP_AMPL_FINE ?
           W'(cand / W'(10)) : cand),
    .digits(rnd_digits),
    .rounded(rnd_out)
  );

  logic [W-1:0] final_val;
  assign final_val = (held_param == wsp_pkg::WSP_P_AMPL && cand >= wsp_pkg::WSP_AMPL_FINE) ?
                     W'(rnd_out * W'(10)) :
                     (held_param == wsp_pkg::WSP_P_OFFS) ?
                     W'(((cand + W'(5)) / W'(10)) * W'(10)) :
                     rnd_out;
  assign in_range = (final_val >= lo_lim) && (final_val <= hi_lim);

  // Keyword checks and cross-parameter conflicts
  assign bad_keyword = (held_param == wsp_pkg::WSP_P_MODUL &&
                        held_value[2:0] > wsp_pkg::WSP_MK_EXT) ||
                       (held_param == wsp_pkg::WSP_P_MODWAVE && held_value[1:0] == 2'h3) ||
                       (held_param == wsp_pkg::WSP_P_TSRC && held_value[1:0] == 2'h3) ||
                       (held_param == wsp_pkg::WSP_P_OUT && held_value[W-1:1] != '0) ||
                       (held_param > wsp_pkg::WSP_P_BUSTRG);
  assign conflict = held_param == wsp_pkg::WSP_P_SWEEP && held_value[1:0] != wsp_pkg::WSP_SK_OFF &&
                    (shape == wsp_pkg::WSP_SH_USR || mod_type == wsp_pkg::WSP_MT_FM);
  assign trg_ok = trig_mode != wsp_pkg::WSP_TM_CONT &&
                  trig_source == wsp_pkg::WSP_TS_BUS;

  ////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      WSP_IDLE: if (cmd_valid) next_state = WSP_ROUND;
      WSP_ROUND: next_state = WSP_APPLY;
      WSP_APPLY: next_state = WSP_IDLE;
      default: next_state = WSP_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state <= WSP_IDLE;
      held_query <= 1'b0;
      held_param <= wsp_pkg::WSP_P_FREQ;
      held_arg <= wsp_pkg::WSP_A_VALUE;
      held_value <= '0;
    end
    else
    begin
      state <= next_state;
      if (state == WSP_IDLE && cmd_valid)
      begin
        held_query <= cmd_query;
        held_param <= cmd_param;
        held_arg <= cmd_arg;
        held_value <= cmd_value;
      end
    end
  end

  logic do_apply;
  logic reject;
  assign do_apply = state == WSP_APPLY && !held_query;
  assign reject = bad_keyword || conflict || (is_numeric && !in_range);

  ////////////////////////////////////////////////////////////////////
  // Settings store, kept unchanged on any rejection
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      carrier_freq <= wsp_pkg::WSP_FREQ_RST;
      step_period <= wsp_pkg::WSP_STEP_RST;
      amplitude <= wsp_pkg::WSP_AMPL_RST;
      offset_mag <= wsp_pkg::WSP_OFFS_RST;
      offset_neg <= 1'b0;
      shape <= wsp_pkg::WSP_SH_SIN;
      mod_type <= wsp_pkg::WSP_MT_OFF;
      mod_ext <= 1'b0;
      am_depth <= wsp_pkg::WSP_DEPTH_RST;
      modulator_tone_cmd <= wsp_pkg::WSP_MTONE_RST;
      modulator_wave_select <= wsp_pkg::WSP_SH_SIN;
      fm_deviation <= wsp_pkg::WSP_DEV_RST;
      sweep_mode <= wsp_pkg::WSP_SW_OFF;
      chirp_duration_cmd <= wsp_pkg::WSP_CDUR_RST;
      chirp_begin_cmd <= wsp_pkg::WSP_CBEG_RST;
      chirp_end_cmd <= wsp_pkg::WSP_CEND_RST;
      pulse_symmetry_cmd <= wsp_pkg::WSP_SYMM_RST;
      out_enable <= 1'b0;
      trig_mode <= wsp_pkg::WSP_TM_CONT;
      trig_source <= wsp_pkg::WSP_TS_INT;
      bus_trigger <= 1'b0;
      err_valid <= 1'b0;
      err_code <= wsp_pkg::WSP_ERR_NONE;
    end
    else
    begin
      bus_trigger <= 1'b0;
      err_valid <= 1'b0;
      if (do_apply && held_param == wsp_pkg::WSP_P_BUSTRG)
      begin
        bus_trigger <= trg_ok;
        err_valid <= !trg_ok;
        err_code <= wsp_pkg::WSP_ERR_TRG_IGN;
      end
      else if (do_apply && reject)
      begin
        err_valid <= 1'b1;
        err_code <= bad_keyword ? wsp_pkg::WSP_ERR_ILLEGAL :
                    conflict ? wsp_pkg::WSP_ERR_CONFLICT : wsp_pkg::WSP_ERR_RANGE;
      end
      else if (do_apply)
      begin
        unique case (held_param)
          wsp_pkg::WSP_P_FREQ: carrier_freq <= final_val;
          wsp_pkg::WSP_P_RATE:
          begin
            step_period <= final_val;
            carrier_freq <= step_freq;
          end
          wsp_pkg::WSP_P_AMPL: amplitude <= final_val;
          wsp_pkg::WSP_P_OFFS:
          begin
            offset_mag <= final_val;
            offset_neg <= held_arg == wsp_pkg::WSP_A_VALUE && held_value[W-1];
          end
          wsp_pkg::WSP_P_SHAPE: shape <= held_value[1:0];
          wsp_pkg::WSP_P_MODUL:
          begin
            // INT/EXT pick the source, AM/FM the type
            if (held_value[2:0] == wsp_pkg::WSP_MK_OFF)
              mod_type <= wsp_pkg::WSP_MT_OFF;
            else if (held_value[2:0] == wsp_pkg::WSP_MK_AM)
              mod_type <= wsp_pkg::WSP_MT_AM;
            else if (held_value[2:0] == wsp_pkg::WSP_MK_FM)
              mod_type <= wsp_pkg::WSP_MT_FM;
            else
              mod_ext <= held_value[2:0] == wsp_pkg::WSP_MK_EXT;
          end
          wsp_pkg::WSP_P_DEPTH: am_depth <= final_val;
          wsp_pkg::WSP_P_MODTONE: modulator_tone_cmd <= final_val;
          wsp_pkg::WSP_P_MODWAVE: modulator_wave_select <= held_value[1:0];
          wsp_pkg::WSP_P_DEV: fm_deviation <= final_val;
          wsp_pkg::WSP_P_SWEEP:
          begin
            // LOG picks the log law, ON and LIN pick linear
            if (held_value[1:0] == wsp_pkg::WSP_SK_OFF)
              sweep_mode <= wsp_pkg::WSP_SW_OFF;
            else if (held_value[1:0] == wsp_pkg::WSP_SK_LOG)
              sweep_mode <= wsp_pkg::WSP_SW_LOG;
            else
              sweep_mode <= wsp_pkg::WSP_SW_LIN;
          end
          wsp_pkg::WSP_P_CHIRPDUR: chirp_duration_cmd <= final_val;
          wsp_pkg::WSP_P_CHIRPBEG: chirp_begin_cmd <= final_val;
          wsp_pkg::WSP_P_CHIRPEND: chirp_end_cmd <= final_val;
          wsp_pkg::WSP_P_SYMM: pulse_symmetry_cmd <= final_val;
          wsp_pkg::WSP_P_OUT: out_enable <= held_value[0];
          wsp_pkg::WSP_P_TMODE: trig_mode <= held_value[1:0];
          wsp_pkg::WSP_P_TSRC: trig_source <= held_value[1:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Query answers
  logic [W-1:0] q_val;
  logic [W-1:0] q_extra;
  always_comb
  begin
    q_extra = '0;
    q_val = '0;
    unique case (held_param)
      wsp_pkg::WSP_P_FREQ: q_val = carrier_freq;
      wsp_pkg::WSP_P_RATE: q_val = step_period;
      wsp_pkg::WSP_P_AMPL: q_val = amplitude;
      wsp_pkg::WSP_P_OFFS:
      begin
        q_val = offset_mag;
        q_extra = W'(offset_neg);
      end
      wsp_pkg::WSP_P_SHAPE: q_val = W'(shape);
      wsp_pkg::WSP_P_MODUL:
      begin
        q_val = W'(mod_type);
        q_extra = W'(mod_ext);
      end
      wsp_pkg::WSP_P_DEPTH: q_val = am_depth;
      wsp_pkg::WSP_P_MODTONE: q_val = modulator_tone_cmd;
      wsp_pkg::WSP_P_MODWAVE: q_val = W'(modulator_wave_select);
      wsp_pkg::WSP_P_DEV: q_val = fm_deviation;
      wsp_pkg::WSP_P_SWEEP: q_val = W'(sweep_mode);
      wsp_pkg::WSP_P_CHIRPDUR: q_val = chirp_duration_cmd;
      wsp_pkg::WSP_P_CHIRPBEG: q_val = chirp_begin_cmd;
      wsp_pkg::WSP_P_CHIRPEND: q_val = chirp_end_cmd;
      wsp_pkg::WSP_P_SYMM: q_val = pulse_symmetry_cmd;
      wsp_pkg::WSP_P_OUT: q_val = W'(out_enable);
      wsp_pkg::WSP_P_TMODE: q_val = W'(trig_mode);
      wsp_pkg::WSP_P_TSRC: q_val = W'(trig_source);
      default: q_val = '0;
    endcase
    if (is_numeric && held_arg != wsp_pkg::WSP_A_VALUE)
      q_val = cand;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_value <= '0;
      rsp_extra <= '0;
    end
    else
    begin
      rsp_valid <= state == WSP_APPLY && held_query;
      if (state == WSP_APPLY && held_query)
      begin
        rsp_value <= q_val;
        rsp_extra <= q_extra;
      end
    end
  end
endmodule

// ---- wsp_parser_assertions.sv ----
`timescale 1ns/10ps
module wsp_parser_checker #(
  parameter int W = 48
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic cmd_query,
  input wire wsp_pkg::wsp_param_t cmd_param,
  input wire logic rsp_valid,
  input wire logic [W-1:0] rsp_value,
  input wire logic err_valid,
  input wire logic [W-1:0] carrier_freq,
  input wire logic [W-1:0] amplitude,
  input wire logic [W-1:0] offset_mag,
  input wire logic [1:0] shape,
  input wire logic [1:0] mod_type,
  input wire logic [W-1:0] am_depth,
  input wire logic [1:0] sweep_mode,
  input wire logic [1:0] trig_mode,
  input wire logic [1:0] trig_source,
  input wire logic bus_trigger
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_AMPL_SPAN: assert property (
    amplitude >= wsp_pkg::WSP_AMPL_MIN && amplitude <= wsp_pkg::WSP_AMPL_MAX)
    else $error("amplitude outside span");
  AST_PEAK_SUM: assert property (
    amplitude + (offset_mag << 1) <= (wsp_pkg::WSP_PEAK_SUM << 1))
    else $error("peak plus offset too large");
  AST_OFFS_STEP: assert property (
    offset_mag <= wsp_pkg::WSP_OFFS_MAX && offset_mag % 10 == 0)
    else $error("offset off grid");
  AST_DEPTH_MAX: assert property (am_depth <= wsp_pkg::WSP_DEPTH_MAX)
    else $error("depth above limit");
  AST_SWEEP_GUARD: assert property (
    $changed(sweep_mode) && sweep_mode != wsp_pkg::WSP_SW_OFF
    |-> shape != wsp_pkg::WSP_SH_USR && mod_type != wsp_pkg::WSP_MT_FM)
    else $error("sweep started while barred");
  AST_BUS_TRIG: assert property (
    bus_trigger |-> trig_mode != wsp_pkg::WSP_TM_CONT && trig_source == wsp_pkg::WSP_TS_BUS)
    else $error("bus trigger accepted wrongly");
  AST_ERR_HOLD: assert property (
    err_valid |-> $stable(carrier_freq) && $stable(amplitude) && $stable(offset_mag))
    else $error("setting changed on error");
  AST_SHAPE_QUERY: assert property (
    cmd_valid && cmd_query && cmd_param == wsp_pkg::WSP_P_SHAPE
    |-> ##3 rsp_valid && rsp_value[1:0] == shape)
    else $error("shape query answer wrong");
endmodule
bind wsp_parser wsp_parser_checker #(.W(W)) chk_i (.*);

// ---- wsp_ctrl_model.sv ----
`timescale 1ns/10ps
module wsp_ctrl_model (
  input wire logic clk,
  input wire logic rsp_valid,
  input wire logic [47:0] rsp_value,
  input wire logic err_valid,
  input wire logic bus_trigger,
  output logic cmd_valid,
  output logic cmd_query,
  output wsp_pkg::wsp_param_t cmd_param,
  output wsp_pkg::wsp_arg_t cmd_arg,
  output logic [47:0] cmd_value
);
  logic got_err;
  logic got_trg;
  logic [47:0] rval;
  initial
  begin
    cmd_valid = 1'b0;
    cmd_query = 1'b0;
    cmd_param = wsp_pkg::WSP_P_FREQ;
    cmd_arg = wsp_pkg::WSP_A_VALUE;
    cmd_value = 48'h0;
  end
  // One unit per message, MIN/MAX never mixed with others
  task automatic send(input logic q, input wsp_pkg::wsp_param_t p,
      input wsp_pkg::wsp_arg_t a, input logic [47:0] v);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_query = q;
    cmd_param = p;
    cmd_arg = a;
    cmd_value = v;
    got_err = 1'b0;
    got_trg = 1'b0;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_value = ~v;
    repeat (4)
    begin
      @(negedge clk);
      got_err = got_err | err_valid;
      got_trg = got_trg | bus_trigger;
      if (rsp_valid)
        rval = rsp_value;
    end
  endtask
endmodule

// ---- tb_waveform_setting_parser.sv ----
`timescale 1ns/10ps
module tb_waveform_setting_parser;
  logic clk;
  logic rst_n;
  logic [9:0] table_length;
  logic cmd_valid;
  logic cmd_query;
  wsp_pkg::wsp_param_t cmd_param;
  wsp_pkg::wsp_arg_t cmd_arg;
  logic [47:0] cmd_value;
  logic rsp_valid;
  logic [47:0] rsp_value;
  logic err_valid;
  logic bus_trigger;
  int n_mismatch = 0;
  int num_checks = 0;
  wsp_parser uut (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_query(cmd_query),
    .cmd_param(cmd_param), .cmd_arg(cmd_arg), .cmd_value(cmd_value),
    .table_length(table_length), .rsp_valid(rsp_valid), .rsp_value(rsp_value),
    .rsp_extra(), .err_valid(err_valid), .err_code(), .carrier_freq(), .step_period(),
    .amplitude(), .offset_mag(), .offset_neg(), .shape(), .mod_type(), .mod_ext(),
    .am_depth(), .modulator_tone_cmd(), .modulator_wave_select(), .fm_deviation(),
    .sweep_mode(), .chirp_duration_cmd(), .chirp_begin_cmd(), .chirp_end_cmd(),
    .pulse_symmetry_cmd(), .out_enable(), .trig_mode(), .trig_source(),
    .bus_trigger(bus_trigger));
  wsp_ctrl_model ctl (
    .clk(clk), .rsp_valid(rsp_valid), .rsp_value(rsp_value), .err_valid(err_valid),
    .bus_trigger(bus_trigger), .cmd_valid(cmd_valid), .cmd_query(cmd_query),
    .cmd_param(cmd_param), .cmd_arg(cmd_arg), .cmd_value(cmd_value));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic st(input wsp_pkg::wsp_param_t p, input logic [47:0] v);
    ctl.send(1'b0, p, wsp_pkg::WSP_A_VALUE, v);
  endtask
  task automatic mx(input wsp_pkg::wsp_param_t p, input wsp_pkg::wsp_arg_t a);
    ctl.send(1'b0, p, a, 48'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_freq;
    st(wsp_pkg::WSP_P_FREQ, wsp_pkg::WSP_FREQ_MAX_SQ);
    chk(uut.carrier_freq, wsp_pkg::WSP_FREQ_MAX_SQ);
    st(wsp_pkg::WSP_P_FREQ, wsp_pkg::WSP_FREQ_MAX_SQ + 48'h2710);
    chk(48'(uut.err_code), 48'(wsp_pkg::WSP_ERR_RANGE));
    chk(uut.carrier_freq, wsp_pkg::WSP_FREQ_MAX_SQ);
    st(wsp_pkg::WSP_P_FREQ, 48'd1234567890123);
    chk(uut.carrier_freq, 48'd1234567890000);
    mx(wsp_pkg::WSP_P_FREQ, wsp_pkg::WSP_A_MIN);
    chk(uut.carrier_freq, wsp_pkg::WSP_FREQ_MIN);
    st(wsp_pkg::WSP_P_SHAPE, 48'(wsp_pkg::WSP_SH_TRI));
    mx(wsp_pkg::WSP_P_FREQ, wsp_pkg::WSP_A_MAX);
    chk(uut.carrier_freq, wsp_pkg::WSP_FREQ_MAX_TRI);
  endtask
  task automatic t_user;
    st(wsp_pkg::WSP_P_SHAPE, 48'(wsp_pkg::WSP_SH_USR));
    mx(wsp_pkg::WSP_P_FREQ, wsp_pkg::WSP_A_MAX);
    chk(uut.carrier_freq, 48'd500000000000);
    mx(wsp_pkg::WSP_P_FREQ, wsp_pkg::WSP_A_MIN);
    chk(uut.carrier_freq, 48'd200);
    st(wsp_pkg::WSP_P_RATE, 48'd1000);
    chk(uut.carrier_freq, 48'd10000000000);
    st(wsp_pkg::WSP_P_SWEEP, 48'(wsp_pkg::WSP_SK_ON));
    chk(48'(ctl.got_err), 48'h1);
  endtask
  task automatic t_level;
    st(wsp_pkg::WSP_P_SHAPE, 48'(wsp_pkg::WSP_SH_SIN));
    st(wsp_pkg::WSP_P_AMPL, 48'd2344);
    chk(uut.amplitude, 48'd2340);
    st(wsp_pkg::WSP_P_OFFS, 48'd4500);
    chk(uut.offset_mag, wsp_pkg::WSP_OFFS_RST);
    st(wsp_pkg::WSP_P_OFFS, 48'd2004);
    chk(uut.offset_mag, 48'd2000);
    mx(wsp_pkg::WSP_P_AMPL, wsp_pkg::WSP_A_MAX);
    chk(uut.amplitude, 48'd6000);
    st(wsp_pkg::WSP_P_DEPTH, 48'd101);
    chk(48'(ctl.got_err), 48'h1);
  endtask
  task automatic t_mod;
    st(wsp_pkg::WSP_P_FREQ, 48'd2000000000000);
    mx(wsp_pkg::WSP_P_DEV, wsp_pkg::WSP_A_MAX);
    chk(uut.fm_deviation, wsp_pkg::WSP_DEV_MAX);
    st(wsp_pkg::WSP_P_MODUL, 48'(wsp_pkg::WSP_MK_FM));
    st(wsp_pkg::WSP_P_MODUL, 48'(wsp_pkg::WSP_MK_EXT));
    chk({uut.mod_type, uut.mod_ext}, {wsp_pkg::WSP_MT_FM, 1'b1});
    st(wsp_pkg::WSP_P_SWEEP, 48'(wsp_pkg::WSP_SK_LOG));
    chk(48'(uut.sweep_mode), 48'(wsp_pkg::WSP_SW_OFF));
    st(wsp_pkg::WSP_P_MODUL, 48'(wsp_pkg::WSP_MK_OFF));
    st(wsp_pkg::WSP_P_SWEEP, 48'(wsp_pkg::WSP_SK_LOG));
    chk(48'(uut.sweep_mode), 48'(wsp_pkg::WSP_SW_LOG));
  endtask
  task automatic t_misc;
    st(wsp_pkg::WSP_P_MODTONE, 48'd12345678);
    chk(uut.modulator_tone_cmd, 48'd12350000);
    st(wsp_pkg::WSP_P_MODWAVE, 48'(wsp_pkg::WSP_SH_TRI));
    chk(48'(uut.modulator_wave_select), 48'(wsp_pkg::WSP_SH_TRI));
    st(wsp_pkg::WSP_P_CHIRPDUR, 48'd9000000);
    chk(uut.chirp_duration_cmd, wsp_pkg::WSP_CDUR_RST);
    mx(wsp_pkg::WSP_P_CHIRPEND, wsp_pkg::WSP_A_MAX);
    chk(uut.chirp_end_cmd, wsp_pkg::WSP_FREQ_MAX_SQ);
    st(wsp_pkg::WSP_P_SYMM, 48'd81);
    chk(uut.pulse_symmetry_cmd, wsp_pkg::WSP_SYMM_RST);
    st(wsp_pkg::WSP_P_OFFS, {1'b1, 47'd1500});
    chk({uut.offset_neg, uut.offset_mag[46:0]}, {1'b1, 47'd1500});
  endtask
  task automatic t_trig;
    st(wsp_pkg::WSP_P_OUT, 48'h1);
    chk(48'(uut.out_enable), 48'h1);
    st(wsp_pkg::WSP_P_TSRC, 48'(wsp_pkg::WSP_TS_BUS));
    st(wsp_pkg::WSP_P_BUSTRG, 48'h0);
    chk(48'(uut.err_code), 48'(wsp_pkg::WSP_ERR_TRG_IGN));
    for (int m = 1; m < 4; m++)
    begin
      st(wsp_pkg::WSP_P_TMODE, 48'(m));
      st(wsp_pkg::WSP_P_BUSTRG, 48'h0);
      chk(48'(ctl.got_trg), 48'h1);
    end
    st(wsp_pkg::WSP_P_FREQ, 48'd1000000000);
    for (int s = 0; s < 4; s++)
    begin
      st(wsp_pkg::WSP_P_SHAPE, 48'(s));
      ctl.send(1'b1, wsp_pkg::WSP_P_SHAPE, wsp_pkg::WSP_A_VALUE, 48'h0);
      chk(ctl.rval, 48'(s));
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #200000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    rst_n = 1'b0;
    table_length = 10'd100;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_freq();
    t_user();
    t_level();
    t_mod();
    t_misc();
    t_trig();
    stop_test();
  end
endmodule
